// ### pkg/pwm_ovr_pkg.sv
/*
 * Constants for the synchronous-update, second interrupt group and output
 * override block: register byte offsets, field positions, reset values, bus codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package pwm_ovr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_UPDATE_PERIOD_BUFFER  = 8'h30;
   localparam logic [7:0] OFS_IRQ2_ENABLE           = 8'h34;
   localparam logic [7:0] OFS_IRQ2_DISABLE          = 8'h38;
   localparam logic [7:0] OFS_IRQ2_MASK             = 8'h3c;
   localparam logic [7:0] OFS_IRQ2_STATUS           = 8'h40;
   localparam logic [7:0] OFS_OVERRIDE_LEVEL        = 8'h44;
   localparam logic [7:0] OFS_OUTPUT_SELECT         = 8'h48;
   localparam logic [7:0] OFS_OUTPUT_SELECT_SET     = 8'h4c;
   localparam logic [7:0] OFS_OUTPUT_SELECT_CLEAR   = 8'h50;
   localparam logic [7:0] OFS_OUTPUT_SELECT_SET_PER = 8'h54;
   localparam logic [7:0] OFS_IRQ2_STATUS_CLEAR     = 8'h70;
   localparam logic [7:0] OFS_UPDATE_PERIOD_STATE   = 8'h74;

   // Field positions
   localparam int unsigned UPD_PERIOD_W   = 4;
   localparam int unsigned BIT_WRITE_RDY  = 0;
   localparam int unsigned BIT_UNDERRUN   = 3;
   localparam int unsigned BASE_CMP_MATCH = 8;
   localparam int unsigned BASE_CMP_UPD   = 16;
   localparam int unsigned BASE_HIGH_SIDE = 0;
   localparam int unsigned BASE_LOW_SIDE  = 16;
   localparam int unsigned STATE_CNT_POS  = 4;

   // Implemented bits of the interrupt and override registers
   localparam logic [31:0] IRQ2_VALID_BITS   = 32'h00ffff09;
   localparam logic [31:0] OVERRIDE_VALID    = 32'h000f000f;

   // Reset values
   localparam logic [31:0] RST_IRQ2_MASK     = 32'h00000000;
   localparam logic [31:0] RST_IRQ2_STATUS   = 32'h00000000;
   localparam logic [31:0] RST_OVERRIDE      = 32'h00000000;
   localparam logic [31:0] RST_OUTPUT_SELECT = 32'h00000000;
   localparam logic [3:0]  RST_UPD_PERIOD    = 4'h0;

   // Sync update modes
   localparam logic [1:0] SYNC_MODE_MANUAL = 2'h0;
   localparam logic [1:0] SYNC_MODE_AUTO   = 2'h1;
   localparam logic [1:0] SYNC_MODE_DMA    = 2'h2;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pwm_ovr_pkg

// ### rtl/pwm_sync_irq_output_override.sv
/*
 * Update-period double buffer and update timer for synchronous channels,
 * second interrupt group (enable/disable/mask/clear-on-read status) and
 * output override selection, behind an AXI4-Lite slave.
 * Assumes event inputs are one-cycle pulses synchronous to aclk, and that
 * period-start pulses come from the channel counters outside this block.
 */
// Behaviour
// - Write-only holding field feeds active update period
// - Auto updates spaced update_period plus one periods
// - Enable/disable writes ignored while group1 protected
// - Interrupt bits: ready 0, underrun 3, 8-15, 16-23
// - Read-only interrupt mask, zero after reset
// - Status read returns flags then clears them
// - Comparison updated flag sticky until status read
// - Comparison match flag sticky until status read
// - Underrun flag sticky until status read
// - Write-ready flag shows new values may be written
// - Override levels: high bits 0-3, low 16-19
// - Select bit picks deadtime output or override
// - Select-set one switches to override immediately
// - Select-clear one returns to deadtime output immediately
// - Period-aligned select-set acts at next channel period
// - Mode one applies updates automatically every update_period plus one periods
`timescale 1ns/1ns
module pwm_sync_irq_output_override #(
   parameter int unsigned NUM_CH  = 4,
   parameter int unsigned NUM_CMP = 8
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Sync channel control and protection status
   input  wire logic [1:0]          sync_update_mode,
   input  wire logic                sw_protect_status_group1,
   input  wire logic                hw_protect_status_group1,
   input  wire logic                sync_period_start,
   output logic                     sync_update_pulse,
   output logic [3:0]               update_period,
   // Interrupt sources
   input  wire logic [NUM_CMP-1:0]  comparison_match_evt,
   input  wire logic [NUM_CMP-1:0]  comparison_update_evt,
   input  wire logic                update_underrun_evt,
   output logic                     irq,
   // Output path
   input  wire logic [NUM_CH-1:0]   channel_period_start,
   input  wire logic [NUM_CH-1:0]   deadtime_high_output,
   input  wire logic [NUM_CH-1:0]   deadtime_low_output,
   output logic [NUM_CH-1:0]        high_side_output,
   output logic [NUM_CH-1:0]        low_side_output
);

   typedef struct packed {
      logic               awready;
      logic               wready;
      logic               aw_held;
      logic               w_held;
      logic [7:0]         awaddr;
      logic [31:0]        wdata;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               arready;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
      logic [3:0]         upd_hold;
      logic               upd_pend;
      logic [3:0]         upd_period;
      logic [3:0]         upd_cnt;
      logic               upd_pulse;
      logic [31:0]        mask;
      logic [31:0]        status;
      logic [31:0]        oov;
      logic [31:0]        osel;
      logic [31:0]        osel_pend;
      logic [NUM_CH-1:0]  hi_out;
      logic [NUM_CH-1:0]  lo_out;
      logic               irq;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Expand byte strobes to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h00000000;
      for (int b = 0; b < 4; b++)
      begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction : lane_mask

   // Both channel sides of channel c in select/override layout
   function automatic logic [31:0] channel_bits(input int unsigned c);
      logic [31:0] m;
      m = 32'h00000000;
      m[pwm_ovr_pkg::BASE_HIGH_SIDE + c] = 1'b1;
      m[pwm_ovr_pkg::BASE_LOW_SIDE + c] = 1'b1;
      return m;
   endfunction : channel_bits

   logic        auto_mode;
   logic        period_elapsed;
   logic [31:0] events;
   logic [31:0] wr_data;
   logic        do_write;
   logic        do_read;
   logic        wr_allowed;

   always_comb
   begin
      st_nxt = st_r;
      auto_mode = (sync_update_mode == pwm_ovr_pkg::SYNC_MODE_AUTO) ||
                  (sync_update_mode == pwm_ovr_pkg::SYNC_MODE_DMA);
      wr_allowed = !sw_protect_status_group1 && !hw_protect_status_group1;

      // Update period timer
      period_elapsed = auto_mode && sync_period_start && (st_r.upd_cnt == st_r.upd_period);
      st_nxt.upd_pulse = period_elapsed;
      if (auto_mode && sync_period_start)
      begin
         // Spacing is update_period + 1 sync periods
         st_nxt.upd_cnt = period_elapsed ? 4'h0 : st_r.upd_cnt + 4'h1;
      end
      // In auto mode the holding value only lands when an update fires, so a smaller value
      // cannot fire an extra update mid-period
      if (st_r.upd_pend && (period_elapsed || !auto_mode))
      begin
         st_nxt.upd_period = st_r.upd_hold;
         st_nxt.upd_pend = 1'b0;
      end

      // Event sources in status layout
      events = 32'h00000000;
      events[pwm_ovr_pkg::BIT_WRITE_RDY] = period_elapsed;
      events[pwm_ovr_pkg::BIT_UNDERRUN] = update_underrun_evt;
      events[pwm_ovr_pkg::BASE_CMP_MATCH +: NUM_CMP] = comparison_match_evt;
      events[pwm_ovr_pkg::BASE_CMP_UPD +: NUM_CMP] = comparison_update_evt;

      // Period-aligned override selection
      for (int unsigned c = 0; c < NUM_CH; c++)
      begin
         if (channel_period_start[c])
         begin
            st_nxt.osel = st_nxt.osel | (st_r.osel_pend & channel_bits(c));
            st_nxt.osel_pend = st_nxt.osel_pend & ~channel_bits(c);
         end
      end

      // AXI write channel capture, either order
      if (s_axi_awvalid && st_r.awready)
      begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready)
      begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = s_axi_wdata & lane_mask(s_axi_wstrb);
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
      end

      do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
      wr_data = st_r.wdata;
      st_nxt.status = st_r.status;
      if (do_write)
      begin
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = pwm_ovr_pkg::RESP_OKAY;
         case ({st_r.awaddr[7:2], 2'b00})
            pwm_ovr_pkg::OFS_UPDATE_PERIOD_BUFFER:
            begin
               st_nxt.upd_hold = wr_data[3:0];
               st_nxt.upd_pend = 1'b1;
            end
            pwm_ovr_pkg::OFS_IRQ2_ENABLE:
            begin
               if (wr_allowed)
               begin
                  st_nxt.mask = st_r.mask | (wr_data & pwm_ovr_pkg::IRQ2_VALID_BITS);
               end
            end
            pwm_ovr_pkg::OFS_IRQ2_DISABLE:
            begin
               if (wr_allowed)
               begin
                  st_nxt.mask = st_r.mask & ~wr_data;
               end
            end
            pwm_ovr_pkg::OFS_IRQ2_STATUS_CLEAR:
            begin
               st_nxt.status = st_r.status & ~wr_data;
            end
            pwm_ovr_pkg::OFS_OVERRIDE_LEVEL:
            begin
               st_nxt.oov = wr_data & pwm_ovr_pkg::OVERRIDE_VALID;
            end
            pwm_ovr_pkg::OFS_OUTPUT_SELECT:
            begin
               st_nxt.osel = wr_data & pwm_ovr_pkg::OVERRIDE_VALID;
            end
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_SET:
            begin
               st_nxt.osel = st_nxt.osel | (wr_data & pwm_ovr_pkg::OVERRIDE_VALID);
            end
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_CLEAR:
            begin
               st_nxt.osel = st_nxt.osel & ~wr_data;
            end
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_SET_PER:
            begin
               st_nxt.osel_pend = st_nxt.osel_pend |
                                  (wr_data & pwm_ovr_pkg::OVERRIDE_VALID);
            end
            pwm_ovr_pkg::OFS_IRQ2_MASK,
            pwm_ovr_pkg::OFS_IRQ2_STATUS,
            pwm_ovr_pkg::OFS_UPDATE_PERIOD_STATE:
            begin
               st_nxt.bresp = pwm_ovr_pkg::RESP_OKAY;
            end
            default:
            begin
               st_nxt.bresp = pwm_ovr_pkg::RESP_SLVERR;
            end
         endcase
      end

      // AXI read channel
      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
      end
      do_read = s_axi_arvalid && st_r.arready;
      if (do_read)
      begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = pwm_ovr_pkg::RESP_OKAY;
         st_nxt.rdata = 32'h00000000;
         case ({s_axi_araddr[7:2], 2'b00})
            pwm_ovr_pkg::OFS_IRQ2_MASK:
            begin
               st_nxt.rdata = st_r.mask;
            end
            pwm_ovr_pkg::OFS_IRQ2_STATUS:
            begin
               st_nxt.rdata = st_r.status;
               st_nxt.status = 32'h00000000;
            end
            pwm_ovr_pkg::OFS_OVERRIDE_LEVEL:
            begin
               st_nxt.rdata = st_r.oov;
            end
            pwm_ovr_pkg::OFS_OUTPUT_SELECT:
            begin
               st_nxt.rdata = st_r.osel;
            end
            pwm_ovr_pkg::OFS_UPDATE_PERIOD_STATE:
            begin
               st_nxt.rdata[3:0] = st_r.upd_period;
               st_nxt.rdata[pwm_ovr_pkg::STATE_CNT_POS +: 4] = st_r.upd_cnt;
            end
            pwm_ovr_pkg::OFS_UPDATE_PERIOD_BUFFER,
            pwm_ovr_pkg::OFS_IRQ2_ENABLE,
            pwm_ovr_pkg::OFS_IRQ2_DISABLE,
            pwm_ovr_pkg::OFS_IRQ2_STATUS_CLEAR,
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_SET,
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_CLEAR,
            pwm_ovr_pkg::OFS_OUTPUT_SELECT_SET_PER:
            begin
               st_nxt.rdata = 32'h00000000;
            end
            default:
            begin
               st_nxt.rresp = pwm_ovr_pkg::RESP_SLVERR;
            end
         endcase
      end

      // New events win over any clear in the same cycle
      st_nxt.status = (st_nxt.status | events) & pwm_ovr_pkg::IRQ2_VALID_BITS;

      st_nxt.irq = |(st_nxt.status & st_nxt.mask);

      // Pin drive, one flop after the select decision
      for (int unsigned c = 0; c < NUM_CH; c++)
      begin
         st_nxt.hi_out[c] = st_nxt.osel[pwm_ovr_pkg::BASE_HIGH_SIDE + c] ?
                            st_nxt.oov[pwm_ovr_pkg::BASE_HIGH_SIDE + c] :
                            deadtime_high_output[c];
         st_nxt.lo_out[c] = st_nxt.osel[pwm_ovr_pkg::BASE_LOW_SIDE + c] ?
                            st_nxt.oov[pwm_ovr_pkg::BASE_LOW_SIDE + c] :
                            deadtime_low_output[c];
      end

      // Ready flags registered; one write and one read in flight
      st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= '0;
         st_r.upd_period <= pwm_ovr_pkg::RST_UPD_PERIOD;
         st_r.mask <= pwm_ovr_pkg::RST_IRQ2_MASK;
         st_r.status <= pwm_ovr_pkg::RST_IRQ2_STATUS;
         st_r.oov <= pwm_ovr_pkg::RST_OVERRIDE;
         st_r.osel <= pwm_ovr_pkg::RST_OUTPUT_SELECT;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready     = st_r.awready;
   assign s_axi_wready      = st_r.wready;
   assign s_axi_bvalid      = st_r.bvalid;
   assign s_axi_bresp       = st_r.bresp;
   assign s_axi_arready     = st_r.arready;
   assign s_axi_rvalid      = st_r.rvalid;
   assign s_axi_rdata       = st_r.rdata;
   assign s_axi_rresp       = st_r.rresp;
   assign sync_update_pulse = st_r.upd_pulse;
   assign update_period     = st_r.upd_period;
   assign irq               = st_r.irq;
   assign high_side_output  = st_r.hi_out;
   assign low_side_output   = st_r.lo_out;

endmodule : pwm_sync_irq_output_override

// ### verification/pwm_ovr_chk.sv
/*
 * Checker for the sync-update, second interrupt group and output override block.
 * Sees only ports of the design top; attached by the bind at the foot of this file.
 */
`timescale 1ns/1ns
module pwm_ovr_chk #(
   parameter int unsigned NUM_CH  = 4,
   parameter int unsigned NUM_CMP = 8
) (
   // Clock and reset
   input wire logic               aclk,
   input wire logic               aresetn,
   // Register bus handshakes
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   // Sync update
   input wire logic [1:0]         sync_update_mode,
   input wire logic               sync_period_start,
   input wire logic               sync_update_pulse,
   // Events and interrupt
   input wire logic [NUM_CMP-1:0] comparison_match_evt,
   input wire logic [NUM_CMP-1:0] comparison_update_evt,
   input wire logic               update_underrun_evt,
   input wire logic               irq,
   // Output path
   input wire logic [NUM_CH-1:0]  channel_period_start,
   input wire logic [NUM_CH-1:0]  deadtime_high_output,
   input wire logic [NUM_CH-1:0]  high_side_output
);
   logic [2:0]        recent_r;
   logic [NUM_CH-1:0] dt_r;
   logic              cause;

   // Anything that may legally move irq or the pins restarts the age count;
   // a register write lands two cycles after its last handshake, so those count too
   assign cause = (|comparison_match_evt) | (|comparison_update_evt) | update_underrun_evt
                | sync_period_start | s_axi_bvalid | (|channel_period_start)
                | (s_axi_awvalid & s_axi_awready) | (s_axi_wvalid & s_axi_wready)
                | (deadtime_high_output != dt_r);

   always_ff @(posedge aclk)
   begin
      dt_r <= deadtime_high_output;
      if (!aresetn || cause)
         recent_r <= 3'h0;
      else if (recent_r != 3'h7)
         recent_r <= recent_r + 3'h1;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response not two cycles after write");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held after handshake");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data held after handshake");
   arready_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted during pending read");
   pulse_cause_a: assert property (sync_update_pulse |-> $past(sync_period_start) &&
      ($past(sync_update_mode) == 2'h1 || $past(sync_update_mode) == 2'h2))
      else $error("update pulse without period start in auto mode");
   irq_cause_a: assert property ($rose(irq) |-> recent_r <= 3'h3)
      else $error("interrupt rose with no recent event or write");
   pins_cause_a: assert property ($changed(high_side_output) |-> recent_r <= 3'h3)
      else $error("high side pins moved with no cause");
endmodule : pwm_ovr_chk

bind pwm_sync_irq_output_override pwm_ovr_chk #(.NUM_CH(NUM_CH), .NUM_CMP(NUM_CMP)) chk_i (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .sync_update_mode, .sync_period_start, .sync_update_pulse,
   .comparison_match_evt, .comparison_update_evt, .update_underrun_evt, .irq,
   .channel_period_start, .deadtime_high_output, .high_side_output);

// ### verification/pwm_sync_irq_output_override_bench.sv
/*
 * Self-checking bench: bus master tasks, register model, event and pin checks.
 * Assumes the design package is compiled first and the checker is bound.
 */
`timescale 1ns/1ns
module pwm_sync_irq_output_override_bench;
   logic        aclk = 0, aresetn = 0, irq, sync_update_pulse;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, mask_m, stat_m, ovr_m, sel_m, d;
   logic [3:0]  s_axi_wstrb = 4'hf, update_period, high_side_output, low_side_output;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic        s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, update_underrun_evt = 0, sync_period_start = 0;
   logic        sw_protect_status_group1 = 0, hw_protect_status_group1 = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r, sync_update_mode = 0;
   logic [3:0]  channel_period_start = 0, deadtime_high_output = 0, deadtime_low_output = 0;
   logic [7:0]  comparison_match_evt = 0, comparison_update_evt = 0;
   logic [15:0] seed = 16'h002c;
   int          fails = 0, checks = 0, pulses = 0;

   pwm_sync_irq_output_override pwm_sync_irq_output_override_i (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .sync_update_mode, .sw_protect_status_group1,
      .hw_protect_status_group1, .sync_period_start, .sync_update_pulse, .update_period,
      .comparison_match_evt, .comparison_update_evt, .update_underrun_evt, .irq,
      .channel_period_start, .deadtime_high_output, .deadtime_low_output,
      .high_side_output, .low_side_output);

   always #4 aclk = ~aclk;
   always @(posedge aclk) if (sync_update_pulse === 1'b1) pulses++;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task rnd(output logic [31:0] v);
      seed = lfsr_next(seed);
      v[15:0] = seed;
      seed = lfsr_next(seed);
      v[31:16] = seed;
   endtask : rnd

   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // Address and data offered together; each dropped at its own handshake
   task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk({30'h0, r}, {30'h0, pwm_ovr_pkg::RESP_OKAY});
   endtask : rchk

   task pins;
      repeat (2) @(posedge aclk);
      chk({12'h0, low_side_output, 12'h0, high_side_output}, pwm_ovr_pkg::OVERRIDE_VALID &
          ((sel_m & ovr_m) | (~sel_m & {12'h0, deadtime_low_output, 12'h0, deadtime_high_output})));
   endtask : pins

   task tick;
      @(posedge aclk) sync_period_start <= 1'b1;
      @(posedge aclk) sync_period_start <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask : tick

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) rchk(8'h3c + 8'(4 * i), 32'h00000000);
      wr(8'h10, 32'h00000001, r);
      chk({30'h0, r}, {30'h0, pwm_ovr_pkg::RESP_SLVERR});
      $display("reset values done");
      mask_m = pwm_ovr_pkg::IRQ2_VALID_BITS;
      wr(8'h34, 32'hffffffff, r);
      rchk(8'h3c, mask_m);
      for (int i = 0; i < 2; i++)
      begin
         @(posedge aclk) {hw_protect_status_group1, sw_protect_status_group1} <= 2'(i + 1);
         wr(8'h38, 32'hffffffff, r);
         rchk(8'h3c, mask_m);
      end
      @(posedge aclk) hw_protect_status_group1 <= 1'b0;
      rnd(d);
      wr(8'h38, d, r);
      wr(8'h3c, 32'h00000000, r);
      wr(8'h34, 32'h00000008, r);
      mask_m = (mask_m & ~d) | 32'h00000008;
      rchk(8'h3c, mask_m);
      $display("mask done");
      rnd(d);
      @(posedge aclk);
      comparison_match_evt <= d[7:0];
      comparison_update_evt <= d[15:8];
      update_underrun_evt <= 1'b1;
      @(posedge aclk);
      comparison_match_evt <= 8'h00;
      comparison_update_evt <= 8'h00;
      update_underrun_evt <= 1'b0;
      stat_m = {8'h00, d[15:0], 8'h08};
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, {31'h0, |(stat_m & mask_m)});
      rchk(8'h40, stat_m);
      rchk(8'h40, 32'h00000000);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq}, 32'h00000000);
      $display("status done");
      rnd(d);
      ovr_m = d & pwm_ovr_pkg::OVERRIDE_VALID;
      wr(8'h44, d, r);
      rchk(8'h44, ovr_m);
      rnd(d);
      @(posedge aclk) {deadtime_low_output, deadtime_high_output} <= d[7:0];
      sel_m = 32'h00000000;
      pins();
      rnd(d);
      wr(8'h4c, d, r);
      sel_m = d & pwm_ovr_pkg::OVERRIDE_VALID;
      rchk(8'h48, sel_m);
      pins();
      rnd(d);
      wr(8'h50, d, r);
      sel_m = sel_m & ~d;
      pins();
      wr(8'h50, 32'hffffffff, r);
      wr(8'h54, 32'h000f000f, r);
      sel_m = 32'h00000000;
      pins();
      @(posedge aclk) channel_period_start <= 4'hf;
      @(posedge aclk) channel_period_start <= 4'h0;
      sel_m = pwm_ovr_pkg::OVERRIDE_VALID;
      pins();
      $display("override done");
      @(posedge aclk) sync_update_mode <= pwm_ovr_pkg::SYNC_MODE_AUTO;
      wr(8'h30, 32'h00000002, r);
      tick();
      chk({28'h0, update_period}, 32'h00000002);
      pulses = 0;
      repeat (9) tick();
      chk(32'(pulses), 32'h00000003);
      rchk(8'h40, 32'h00000001);
      @(posedge aclk) sync_update_mode <= pwm_ovr_pkg::SYNC_MODE_MANUAL;
      pulses = 0;
      repeat (3) tick();
      chk(32'(pulses), 32'h00000000);
      @(posedge aclk) sync_update_mode <= pwm_ovr_pkg::SYNC_MODE_DMA;
      pulses = 0;
      repeat (4) tick();
      chk(32'(pulses), 32'h00000001);
      rchk(8'h74, 32'h00000012);
      wr(8'h70, 32'h00000001, r);
      rchk(8'h40, 32'h00000000);
      $display("update period done");
      tally_and_finish();
   end

   // The tests take well under a thousand cycles; twenty thousand means a hang
   initial
   begin
      #(8 * 20000);
      fails++;
      tally_and_finish();
   end

   task tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
endmodule : pwm_sync_irq_output_override_bench
